/* File: rtl/piu_top.sv */
// Pin interrupt unit: AHB-Lite registers, edge and level detection, interrupts and events
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "piu_regs.svh"

module piu_top #(
    parameter int LINES = 18,
    parameter int SYNC_CYCLES = `PIU_SYNC_CYCLES_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [LINES-1:0] line_pin,
    input wire logic nmi_pin,
    output logic line_irq,
    output logic nmi_irq,
    output logic [LINES-1:0] line_event_out,
    output logic ctl_irq
);

    localparam int PINS = LINES + 1;
    localparam int NMI = LINES;

    // ****************************************
    // Elaboration checks
    // ****************************************
    initial begin
        if (LINES < 1 || LINES > 24) begin
            $error("LINES must lie in 1..24, three config words serve 24 lines");
        end
        if (SYNC_CYCLES < 1 || SYNC_CYCLES > `PIU_SYNC_CYCLES_MAX) begin
            $error("SYNC_CYCLES must lie in 1..32");
        end
    end

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [31:0] lane_mask(input logic [2:0] size, input logic [1:0] low);
        logic [3:0] be;
        be = 4'hF;
        if (size == 3'h0) begin
            be = 4'h1 << low;
        end else if (size == 3'h1) begin
            be = low[1] ? 4'hC : 4'h3;
        end
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Detection against one trigger select code; reserved codes detect nothing
    function automatic logic sense_hit(input logic [2:0] sel, input logic now, input logic prev);
        case (sel)
            piu_pkg::PIU_SENSE_RISE: return now & ~prev;
            piu_pkg::PIU_SENSE_FALL: return ~now & prev;
            piu_pkg::PIU_SENSE_BOTH: return now ^ prev;
            piu_pkg::PIU_SENSE_HIGH: return now;
            piu_pkg::PIU_SENSE_LOW: return ~now;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic majority(input logic [2:0] s);
        return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction

    // ****************************************
    // State declarations
    // ****************************************
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_idx;
    logic [31:0] dp_mask;
    piu_pkg::piu_sync_t sy_state;
    logic [5:0] sy_cnt;
    logic soft_reset_bit_busy;
    logic enable_req;
    logic enable_eff;
    logic [3:0] nmi_ctrl;
    logic nmi_flag;
    logic [LINES-1:0] line_event_control;
    logic [LINES-1:0] inten;
    logic [LINES-1:0] line_flag_reg;
    logic [31:0] cfg [3];
    logic [1:0] cst;
    logic [1:0] cst_en;
    logic [2:0] hist [PINS];
    logic [PINS-1:0] level_prev;
    logic [PINS-1:0] level_now;
    logic [PINS-1:0] hit;
    logic accept;
    logic [7:0] a_idx;
    logic wr_commit;
    logic [31:0] wd;
    logic wr_ctrl;
    logic soft_rst;
    logic sync_pending;
    logic sync_done;
    logic [31:0] next_rdata;

    // ****************************************
    // Bus decode
    // ****************************************
    assign accept = hsel & htrans[1] & hready;
    assign a_idx = haddr[9:2];
    assign wr_commit = dp_valid & dp_write & hreadyout;
    assign wd = hwdata & dp_mask;
    assign wr_ctrl = wr_commit && dp_idx == `PIU_IDX_CTRL;
    assign sync_pending = sy_state != piu_pkg::PIU_SY_IDLE;
    assign sync_done = sy_state == piu_pkg::PIU_SY_END;
    assign soft_rst = sync_done & soft_reset_bit_busy;

    // Data phase capture; reads take one wait so that they see every earlier write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_idx <= `PIU_RST_BYTE;
            dp_mask <= `PIU_RST_WORD;
        end else if (accept) begin
            dp_valid <= 1'b1;
            dp_write <= hwrite;
            dp_idx <= a_idx;
            dp_mask <= lane_mask(hsize, haddr[1:0]);
        end else if (hreadyout) begin
            dp_valid <= 1'b0;
        end
    end

    // Wait states: a read waits one cycle, a control write waits out a running sync
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else if (accept && !hwrite) begin
            hreadyout <= 1'b0;
        end else if (accept && a_idx == `PIU_IDX_CTRL && (sync_pending || wr_ctrl)) begin
            hreadyout <= 1'b0;
        end else if (dp_valid && !hreadyout && (!dp_write || !sync_pending || sync_done)) begin
            hreadyout <= 1'b1;
        end
    end

    // Every response is OKAY; unmapped reads give zero and unmapped writes vanish
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Read multiplexer; narrower registers sit in the low bits, except the sync pending flag at bit 7
    always_comb begin
        next_rdata = `PIU_RST_WORD;
        case (dp_idx)
            `PIU_IDX_CTRL: begin
                next_rdata[`PIU_CTRL_SOFT_RESET_BIT] = soft_reset_bit_busy;
                next_rdata[`PIU_CTRL_ENABLE] = enable_req;
            end
            `PIU_IDX_SYNC_STATE: next_rdata[`PIU_SYNC_PENDING] = sync_pending;
            `PIU_IDX_NMI_CTRL: next_rdata[3:0] = nmi_ctrl;
            `PIU_IDX_NMI_FLAG: next_rdata[`PIU_NMI_FLAG_BIT] = nmi_flag;
            `PIU_IDX_LINE_EVENT_CONTROL: next_rdata[LINES-1:0] = line_event_control;
            `PIU_IDX_IEN_CLR: next_rdata[LINES-1:0] = inten;
            `PIU_IDX_IEN_SET: next_rdata[LINES-1:0] = inten;
            `PIU_IDX_FLAG: next_rdata[LINES-1:0] = line_flag_reg;
            `PIU_IDX_CFG0: next_rdata = cfg[0];
            `PIU_IDX_CFG1: next_rdata = cfg[1];
            `PIU_IDX_CFG2: next_rdata = cfg[2];
            `PIU_IDX_CST: next_rdata[1:0] = cst;
            `PIU_IDX_CST_EN: next_rdata[1:0] = cst_en;
            default: next_rdata = `PIU_RST_WORD;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `PIU_RST_WORD;
        end else if (dp_valid && !dp_write && !hreadyout) begin
            hrdata <= next_rdata;
        end
    end

    // ****************************************
    // Control and synchronization
    // ****************************************
    // Enable reads back at once but only takes effect when the sync ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_reset_bit_busy <= 1'b0;
            enable_req <= 1'b0;
            enable_eff <= 1'b0;
        end else begin
            if (soft_rst) begin
                soft_reset_bit_busy <= 1'b0;
                enable_req <= 1'b0;
                enable_eff <= 1'b0;
            end else if (sync_done) begin
                enable_eff <= enable_req;
            end
            if (wr_ctrl && dp_mask[`PIU_CTRL_SOFT_RESET_BIT]) begin
                if (wd[`PIU_CTRL_SOFT_RESET_BIT]) begin
                    soft_reset_bit_busy <= 1'b1;
                end else if (dp_mask[`PIU_CTRL_ENABLE]) begin
                    enable_req <= wd[`PIU_CTRL_ENABLE];
                end
            end else if (wr_ctrl && dp_mask[`PIU_CTRL_ENABLE]) begin
                enable_req <= wd[`PIU_CTRL_ENABLE];
            end
        end
    end

    // Sequencer standing in for the crossing into the peripheral domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sy_state <= piu_pkg::PIU_SY_IDLE;
            sy_cnt <= 6'h00;
        end else begin
            case (sy_state)
                piu_pkg::PIU_SY_IDLE: begin
                    if (wr_ctrl && dp_mask[1:0] != 2'h0) begin
                        sy_state <= (SYNC_CYCLES == 1) ? piu_pkg::PIU_SY_END
                                                       : piu_pkg::PIU_SY_RUN;
                        sy_cnt <= 6'(SYNC_CYCLES - 1);
                    end
                end
                piu_pkg::PIU_SY_RUN: begin
                    sy_cnt <= sy_cnt - 6'h01;
                    if (sy_cnt == 6'h01) begin
                        sy_state <= piu_pkg::PIU_SY_END;
                    end
                end
                piu_pkg::PIU_SY_END: sy_state <= piu_pkg::PIU_SY_IDLE;
                default: sy_state <= piu_pkg::PIU_SY_IDLE;
            endcase
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_ctrl <= 4'h0;
            line_event_control <= '0;
            cfg[0] <= `PIU_RST_WORD;
            cfg[1] <= `PIU_RST_WORD;
            cfg[2] <= `PIU_RST_WORD;
            cst_en <= 2'h0;
        end else if (soft_rst) begin
            nmi_ctrl <= 4'h0;
            line_event_control <= '0;
            cfg[0] <= `PIU_RST_WORD;
            cfg[1] <= `PIU_RST_WORD;
            cfg[2] <= `PIU_RST_WORD;
            cst_en <= 2'h0;
        end else if (wr_commit) begin
            case (dp_idx)
                `PIU_IDX_NMI_CTRL: nmi_ctrl <= (nmi_ctrl & ~dp_mask[3:0]) | wd[3:0];
                `PIU_IDX_LINE_EVENT_CONTROL:
                    line_event_control <= (line_event_control & ~dp_mask[LINES-1:0]) | wd[LINES-1:0];
                `PIU_IDX_CFG0: cfg[0] <= (cfg[0] & ~dp_mask) | wd;
                `PIU_IDX_CFG1: cfg[1] <= (cfg[1] & ~dp_mask) | wd;
                `PIU_IDX_CFG2: cfg[2] <= (cfg[2] & ~dp_mask) | wd;
                `PIU_IDX_CST_EN: cst_en <= (cst_en & ~dp_mask[1:0]) | wd[1:0];
                default: ;
            endcase
        end
    end

    // Shared enable state behind the set and clear views
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inten <= '0;
        end else if (soft_rst) begin
            inten <= '0;
        end else if (wr_commit && dp_idx == `PIU_IDX_IEN_CLR) begin
            inten <= inten & ~wd[LINES-1:0];
        end else if (wr_commit && dp_idx == `PIU_IDX_IEN_SET) begin
            inten <= inten | wd[LINES-1:0];
        end
    end

    // ****************************************
    // Input filtering and detection
    // ****************************************
    // Majority of three samples; costs one cycle of latency when on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < PINS; i++) begin
                hist[i] <= 3'h0;
            end
            level_prev <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                hist[i] <= {hist[i][1:0], line_pin[i]};
            end
            hist[NMI] <= {hist[NMI][1:0], nmi_pin};
            level_prev <= level_now;
        end
    end

    // Lines follow the config words and unit enable; the nonmaskable input is always live
    always_comb begin
        logic [3:0] nib;
        nib = 4'h0;
        for (int i = 0; i < PINS; i++) begin
            if (i == NMI) begin
                nib = nmi_ctrl;
            end else begin
                nib = cfg[i / 8][(i % 8) * 4 +: 4];
            end
            level_now[i] = nib[`PIU_NMI_FILTER] ? majority(hist[i]) : hist[i][0];
            hit[i] = sense_hit(nib[2:0], level_now[i], level_prev[i])
                     & (enable_eff | (i == NMI));
        end
    end

    // ****************************************
    // Flags, requests and events
    // ****************************************
    // A detection in the same cycle as a clearing write wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_flag_reg <= '0;
            nmi_flag <= 1'b0;
        end else if (soft_rst) begin
            line_flag_reg <= '0;
            nmi_flag <= 1'b0;
        end else begin
            if (wr_commit && dp_idx == `PIU_IDX_FLAG) begin
                line_flag_reg <= (line_flag_reg & ~wd[LINES-1:0]) | hit[LINES-1:0];
            end else begin
                line_flag_reg <= line_flag_reg | hit[LINES-1:0];
            end
            if (wr_commit && dp_idx == `PIU_IDX_NMI_FLAG) begin
                nmi_flag <= (nmi_flag & ~wd[`PIU_NMI_FLAG_BIT]) | hit[NMI];
            end else begin
                nmi_flag <= nmi_flag | hit[NMI];
            end
        end
    end

    // Control events: sync finished and nonmaskable detection, cleared by write-one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cst <= 2'h0;
        end else begin
            cst[`PIU_CST_SYNC_DONE] <= (cst[`PIU_CST_SYNC_DONE] & ~(wr_commit
                && dp_idx == `PIU_IDX_CST_CLR && wd[`PIU_CST_SYNC_DONE])) | sync_done;
            cst[`PIU_CST_NMI_SEEN] <= (cst[`PIU_CST_NMI_SEEN] & ~(wr_commit
                && dp_idx == `PIU_IDX_CST_CLR && wd[`PIU_CST_NMI_SEEN])) | hit[NMI];
        end
    end

    // Registered request and event outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_irq <= 1'b0;
            nmi_irq <= 1'b0;
            ctl_irq <= 1'b0;
            line_event_out <= '0;
        end else begin
            line_irq <= |(line_flag_reg & inten);
            nmi_irq <= nmi_flag;
            ctl_irq <= |(cst & cst_en);
            line_event_out <= hit[LINES-1:0] & line_event_control;
        end
    end

    // ****************************************
    // Assertions and covers
    // ****************************************
    localparam int SYNC_BOUND = 40;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_soft_reset_bit_clears_all: assert property (soft_rst |=>
        inten == '0 && line_event_control == '0 && !enable_eff && !enable_req && !nmi_flag)
        else $error("soft reset left state behind");
    chk_soft_reset_bit_drops_rest: assert property (
        (wr_ctrl && wd[`PIU_CTRL_SOFT_RESET_BIT] && dp_mask[`PIU_CTRL_SOFT_RESET_BIT]) |=>
        soft_reset_bit_busy && enable_req == $past(enable_req))
        else $error("soft reset write kept other bits");
    chk_soft_reset_bit_with_sync: assert property ($fell(soft_reset_bit_busy) |->
        !sync_pending && $past(sync_done)) else $error("soft reset bit cleared apart from sync");
    chk_sync_bounded: assert property ($rose(sync_pending) |->
        ##[1:SYNC_BOUND] !sync_pending) else $error("sync never finished");
    chk_sync_starts: assert property ((wr_ctrl && !sync_pending) |=> sync_pending)
        else $error("control write did not start sync");
    chk_nmi_flag_irq: assert property ((hit[NMI] && !soft_rst) |=> nmi_flag ##1 nmi_irq)
        else $error("nonmaskable detection lost");
    chk_nmi_flag_clear: assert property (
        (wr_commit && dp_idx == `PIU_IDX_NMI_FLAG && wd[`PIU_NMI_FLAG_BIT] && !hit[NMI])
        |=> !nmi_flag)
        else $error("nonmaskable flag not cleared");
    chk_event_gated: assert property (
        (line_event_out & ~$past(line_event_control)) == '0) else $error("event without enable");
    chk_enable_clear: assert property (
        (wr_commit && dp_idx == `PIU_IDX_IEN_CLR) |=> (inten & $past(wd[LINES-1:0])) == '0)
        else $error("enable not cleared");
    chk_flag_on_hit: assert property (
        (hit[LINES-1:0] != '0 && !soft_rst) |=> (line_flag_reg & $past(hit[LINES-1:0])) ==
        $past(hit[LINES-1:0])) else $error("line flag not set");
    chk_ctrl_stall: assert property (
        (accept && hwrite && a_idx == `PIU_IDX_CTRL && sync_pending && !sync_done) |=>
        !hreadyout) else $error("control write not stalled");
    chk_irq_or: assert property (((line_flag_reg & inten) != '0) [*2] |-> line_irq)
        else $error("maskable request missing");

    cov_soft_reset: cover property (soft_rst);
    cov_stalled_write: cover property (dp_valid && dp_write && !hreadyout ##[1:40] wr_ctrl);
    cov_nmi: cover property (hit[NMI] ##2 nmi_irq);
    cov_event: cover property (line_event_out != '0);

endmodule

`default_nettype wire

/* File: rtl/piu_regs.svh */
// Register indices, field positions, reset values and counts of the pin interrupt unit
`ifndef PIU_REGS_SVH
`define PIU_REGS_SVH

// Register indices; byte address is four times the index
`define PIU_IDX_CTRL 8'h00
`define PIU_IDX_SYNC_STATE 8'h01
`define PIU_IDX_NMI_CTRL 8'h02
`define PIU_IDX_NMI_FLAG 8'h03
`define PIU_IDX_LINE_EVENT_CONTROL 8'h04
`define PIU_IDX_IEN_CLR 8'h08
`define PIU_IDX_IEN_SET 8'h0C
`define PIU_IDX_FLAG 8'h10
`define PIU_IDX_CFG0 8'h18
`define PIU_IDX_CFG1 8'h1C
`define PIU_IDX_CFG2 8'h20
`define PIU_IDX_CST 8'h28
`define PIU_IDX_CST_CLR 8'h29
`define PIU_IDX_CST_EN 8'h2A

// Field positions
`define PIU_CTRL_SOFT_RESET_BIT 0
`define PIU_CTRL_ENABLE 1
`define PIU_SYNC_PENDING 7
`define PIU_NMI_FILTER 3
`define PIU_NMI_FLAG_BIT 0
`define PIU_CST_SYNC_DONE 0
`define PIU_CST_NMI_SEEN 1

// Reset values
`define PIU_RST_BYTE 8'h00
`define PIU_RST_WORD 32'h00000000

// Default synchronization delay in hclk cycles, and its upper bound
`define PIU_SYNC_CYCLES_DEF 4
`define PIU_SYNC_CYCLES_MAX 32

`endif

/* File: rtl/piu_pkg.sv */
// Types shared by the pin interrupt unit
package piu_pkg;

    // Trigger select codes for every input
    typedef enum logic [2:0] {
        PIU_SENSE_NONE = 3'h0,
        PIU_SENSE_RISE = 3'h1,
        PIU_SENSE_FALL = 3'h2,
        PIU_SENSE_BOTH = 3'h3,
        PIU_SENSE_HIGH = 3'h4,
        PIU_SENSE_LOW = 3'h5
    } piu_sense_t;

    // Synchronization sequencer, Gray coded along idle, run, end
    typedef enum logic [1:0] {
        PIU_SY_IDLE = 2'b00,
        PIU_SY_RUN = 2'b01,
        PIU_SY_END = 2'b11
    } piu_sync_t;

endpackage

/* File: dv/piu_pin_model.sv */
// Behavioural model of the external pins and of the event consumer
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Pin driver and event counter
// ****************************************
module piu_pin_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [17:0] want_line,
    input wire logic want_nmi,
    input wire logic [17:0] line_event_out,
    output logic [17:0] line_pin,
    output logic nmi_pin,
    output logic [15:0] ev_count
);
    // Pins move only just after an edge, like a source synchronous to hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_pin <= 18'h00000;
            nmi_pin <= 1'b0;
        end else begin
            line_pin <= want_line;
            nmi_pin <= want_nmi;
        end
    end
    // Every pulse counts, so a pulse held too long shows as extra events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_count <= 16'h0000;
        end else begin
            ev_count <= ev_count + 16'($countones(line_event_out));
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking testbench of the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "piu_regs.svh"

// ****************************************
// Bench top
// ****************************************
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, line_irq, nmi_irq, ctl_irq, nmi_pin;
    logic [17:0] line_pin, line_event_out;
    logic [17:0] want_line = 18'h00000;
    logic want_nmi = 1'b0;
    logic [15:0] ev_count;
    int n_mismatch = 0;
    int comparisons = 0;
    int last_cycles = 0;

    always #12.5 hclk = ~hclk;

    piu_top #(.LINES(18), .SYNC_CYCLES(4)) piu_top_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .line_pin(line_pin), .nmi_pin(nmi_pin), .line_irq(line_irq),
        .nmi_irq(nmi_irq), .line_event_out(line_event_out), .ctl_irq(ctl_irq));
    piu_pin_model piu_pin_model_inst (.hclk(hclk), .hresetn(hresetn), .want_line(want_line),
        .want_nmi(want_nmi), .line_event_out(line_event_out), .line_pin(line_pin),
        .nmi_pin(nmi_pin), .ev_count(ev_count));

    task automatic test_done();
        $display("Mismatches %0d in %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Registered outputs still show their sampled value right after the edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            last_cycles++;
        end while (hreadyout !== 1'b1 && n < 60);
        if (n >= 60) begin
            n_mismatch++;
            test_done();
        end
    endtask

    // One single word transfer; read data is taken at the closing edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        last_cycles = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h000000, idx, 2'b00};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Poll until the pending sync has ended, bounded
    task automatic wait_sync();
        int n;
        n = 0;
        do begin
            bus(1'b0, `PIU_IDX_SYNC_STATE, 32'h0);
            n++;
        end while (rd[7] !== 1'b0 && n < 40);
        chk("sync finished", 32'h0, rd);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] idx [8];
        idx = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0C, 8'h10, 8'h3F};
        foreach (idx[i]) rdchk("reset value", idx[i], 32'h0);
    endtask

    // Second sync write lands while the first is pending and must stall
    task automatic t_enable();
        wr(`PIU_IDX_CTRL, 32'h2);
        wr(`PIU_IDX_CTRL, 32'h2);
        chk("stalled write", 32'h1, {31'h0, last_cycles > 2});
        rdchk("sync pending", `PIU_IDX_SYNC_STATE, 32'h80);
        wait_sync();
        rdchk("enable readback", `PIU_IDX_CTRL, 32'h2);
    endtask

    task automatic t_enables();
        wr(`PIU_IDX_IEN_SET, 32'h30005);
        rdchk("enable set", `PIU_IDX_IEN_CLR, 32'h30005);
        wr(`PIU_IDX_IEN_SET, 32'h0);
        wr(`PIU_IDX_IEN_CLR, 32'h1);
        rdchk("enable clear", `PIU_IDX_IEN_SET, 32'h30004);
    endtask

    task automatic t_line();
        wr(`PIU_IDX_CFG0, 32'h400);
        want_line <= 18'h00004;
        cyc(8);
        chk("line irq", 32'h1, {31'h0, line_irq});
        rdchk("line flag", `PIU_IDX_FLAG, 32'h4);
        wr(`PIU_IDX_IEN_CLR, 32'h4);
        cyc(3);
        chk("masked irq", 32'h0, {31'h0, line_irq});
        want_line <= 18'h00000;
        cyc(6);
        wr(`PIU_IDX_FLAG, 32'h0);
        rdchk("flag kept", `PIU_IDX_FLAG, 32'h4);
        wr(`PIU_IDX_FLAG, 32'h4);
        rdchk("flag cleared", `PIU_IDX_FLAG, 32'h0);
        wr(`PIU_IDX_CFG2, 32'h10);
        want_line <= 18'h20000;
        cyc(8);
        rdchk("top line flag", `PIU_IDX_FLAG, 32'h20000);
        chk("top line irq", 32'h1, {31'h0, line_irq});
        wr(`PIU_IDX_CFG0, 32'h9);
        want_line <= 18'h20001;
        cyc(1);
        want_line <= 18'h20000;
        cyc(6);
        rdchk("filtered line", `PIU_IDX_FLAG, 32'h20000);
        want_line <= 18'h00000;
        wr(`PIU_IDX_FLAG, 32'h3FFFF);
    endtask

    // Two lines rise together; only the one with its event enabled may pulse
    task automatic t_event();
        logic [15:0] base;
        wr(`PIU_IDX_LINE_EVENT_CONTROL, 32'h1);
        wr(`PIU_IDX_CFG0, 32'h11);
        base = ev_count;
        want_line <= 18'h00003;
        cyc(8);
        chk("event count", {16'h0, base + 16'h1}, {16'h0, ev_count});
        want_line <= 18'h00000;
        wr(`PIU_IDX_FLAG, 32'h3FFFF);
    endtask

    // Low hold, rise, fall after clears; masks give the codes that must set
    task automatic t_nmi();
        logic [7:0] c;
        for (int k = 0; k < 8; k++) begin
            c = 8'(k);
            wr(`PIU_IDX_NMI_CTRL, {24'h0, c});
            cyc(6);
            wr(`PIU_IDX_NMI_FLAG, 32'h1);
            cyc(6);
            rdchk("nmi low", `PIU_IDX_NMI_FLAG, {31'h0, 1'(8'h20 >> c)});
            want_nmi <= 1'b1;
            cyc(6);
            wr(`PIU_IDX_NMI_FLAG, 32'h0);
            rdchk("nmi rise", `PIU_IDX_NMI_FLAG, {31'h0, 1'(8'h3A >> c)});
            wr(`PIU_IDX_NMI_FLAG, 32'h1);
            want_nmi <= 1'b0;
            cyc(6);
            rdchk("nmi fall", `PIU_IDX_NMI_FLAG, {31'h0, 1'(8'h3C >> c)});
            chk("nmi irq", {31'h0, 1'(8'h3C >> c)}, {31'h0, nmi_irq});
        end
        for (int f = 0; f < 2; f++) begin
            wr(`PIU_IDX_NMI_CTRL, (f == 0) ? 32'h9 : 32'h1);
            wr(`PIU_IDX_NMI_FLAG, 32'h1);
            want_nmi <= 1'b1;
            cyc(1);
            want_nmi <= 1'b0;
            cyc(6);
            rdchk("nmi glitch", `PIU_IDX_NMI_FLAG, 32'(f));
        end
    endtask

    // Control status interrupt: raised by a sync, masked, then cleared
    task automatic t_ctl();
        wr(`PIU_IDX_CST_CLR, 32'h3);
        wr(`PIU_IDX_CTRL, 32'h2);
        wait_sync();
        rdchk("sync done", `PIU_IDX_CST, 32'h1);
        wr(`PIU_IDX_CST_EN, 32'h0);
        cyc(2);
        chk("ctl irq masked", 32'h0, {31'h0, ctl_irq});
        wr(`PIU_IDX_CST_EN, 32'h1);
        cyc(2);
        chk("ctl irq raised", 32'h1, {31'h0, ctl_irq});
        wr(`PIU_IDX_CST_CLR, 32'h1);
        cyc(2);
        chk("ctl irq cleared", 32'h0, {31'h0, ctl_irq});
    endtask

    task automatic t_soft_reset_bit();
        wr(`PIU_IDX_LINE_EVENT_CONTROL, 32'h1);
        wr(`PIU_IDX_NMI_CTRL, 32'h4);
        wr(`PIU_IDX_CTRL, 32'h3);
        bus(1'b0, `PIU_IDX_CTRL, 32'h0);
        chk("reset ongoing", 32'h1, {31'h0, rd[0]});
        wait_sync();
        rdchk("ctrl after reset", `PIU_IDX_CTRL, 32'h0);
        rdchk("events after reset", `PIU_IDX_LINE_EVENT_CONTROL, 32'h0);
        rdchk("enables after reset", `PIU_IDX_IEN_SET, 32'h0);
        rdchk("nmi ctrl after reset", `PIU_IDX_NMI_CTRL, 32'h0);
        wr(`PIU_IDX_CTRL, 32'h3);
        bus(1'b0, `PIU_IDX_CTRL, 32'h0);
        chk("enable discarded", 32'h1, rd);
        wait_sync();
        rdchk("ctrl after second reset", `PIU_IDX_CTRL, 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_enable();
        t_enables();
        t_line();
        t_event();
        t_nmi();
        t_ctl();
        t_soft_reset_bit();
        test_done();
    end
endmodule
`default_nettype wire
